// ===== rtl/mfseq_pkg.sv
// types for the manual function sequencer
package mfseq_pkg;
   typedef enum logic [2:0] {
      MF_IDLE = 3'b000,
      MF_S0 = 3'b001,
      MF_S1 = 3'b010,
      MF_S2 = 3'b011,
      MF_WAIT_REL = 3'b100
   } mfseq_phase_type;
   typedef struct packed {
      logic set_location;
      logic start;
      logic inspect;
      logic store_word;
      logic resume;
   } mfseq_keys_type;
   typedef struct packed {
      logic switch_bus_gate;
      logic counter_bus_gate;
      logic address_reg_bus_gate;
      logic carry_insert;
      logic address_reg_strobe;
      logic counter_strobe;
      logic mem_start;
      logic preset;
      logic run_clear_enable;
   } mfseq_ctrl_type;
   typedef struct packed {
      logic read_drive;
      logic write_drive;
      logic [63:0] y_line;
      logic [11:0] inhibit;
   } mfseq_core_type;
endpackage

// ===== rtl/mfseq_regs.svh
// timing constants and field positions for the manual function sequencer
// Function
// - start sequence on rising edge of any of five console key levels.
// - debounce each key with about 100 ms filter delay before acting.
// - initial manual state only while run is clear; nothing while running.
// - initial state sets first-state flip-flop and emits initial pulse.
// - initial state with inspect or store-word enables run clear at time three.
// - second manual pulse comes 2 us after the initial pulse.
// - second pulse sets second-state flop, which clears first-state flop.
// - third pulse 2 us after second; it clears the second-state flop.
// - final manual state level comes from cleared second-state flop.
// - every manual pulse lasts 150 ns, within 50 ns.
// - set-location initial pulse gives preset, clearing major state register.
// - set-location gates switches to bus, loads address then counter.
// - store-word initial pulse gives preset, clearing major state registers.
// - store-word first state gates counter to bus, loads address register.
// - store-word second state increments address into counter at third pulse.
// - every key but set-location emits memory start at third pulse.
// - store-word final state gates switch register onto bus.
// - buffer captures bus at time pulse two; write stores at address.
// - counter advance lets repeated store-word fill consecutive words.
// - same winding path read and write, current direction reversed.
// - Y line decoded from address bits 6 to 11; zero selects line 00.
// - inhibit active exactly where buffer bit is zero during write.
// - preset sets time state one and clears time states two to four.
`ifndef MFSEQ_REGS_SVH
`define MFSEQ_REGS_SVH
`define MFSEQ_CLK_MHZ 50
`define MFSEQ_FILTER_MS 100
`define MFSEQ_FILTER_CYC (`MFSEQ_FILTER_MS * 1000 * `MFSEQ_CLK_MHZ)
`define MFSEQ_GAP_US 2
`define MFSEQ_GAP_CYC (`MFSEQ_GAP_US * `MFSEQ_CLK_MHZ)
`define MFSEQ_PULSE_NS 150
`define MFSEQ_PULSE_CYC ((`MFSEQ_PULSE_NS * `MFSEQ_CLK_MHZ + 999) / 1000)
`define MFSEQ_KEY_SETLOC 0
`define MFSEQ_KEY_START 1
`define MFSEQ_KEY_INSPECT 2
`define MFSEQ_KEY_STORE 3
`define MFSEQ_KEY_RESUME 4
`define MFSEQ_YSEL_LSB 6
`endif

// ===== rtl/mfseq_top.sv
// manual function sequencer with register transfers and core drive selection
//
// The implementer's own choice: the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mfseq_regs.svh"
module mfseq_top #(
   parameter int FILTER_CYC = `MFSEQ_FILTER_CYC,
   parameter int GAP_CYC = `MFSEQ_GAP_CYC,
   parameter int PULSE_CYC = `MFSEQ_PULSE_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire mfseq_pkg::mfseq_keys_type keys_i,
   input wire logic run_i,
   input wire logic [11:0] switch_register_i,
   input wire logic [11:0] bus_i,
   input wire logic time_pulse_two_i,
   input wire logic mem_read_i,
   input wire logic mem_write_i,
   output logic manual_state_initial_o,
   output logic manual_state_first_o,
   output logic manual_state_second_o,
   output logic manual_state_final_o,
   output logic manual_pulse_initial_o,
   output logic manual_pulse_second_o,
   output logic manual_pulse_third_o,
   output mfseq_pkg::mfseq_ctrl_type ctrl_o,
   output logic time_state_one_o,
   output logic [2:0] time_state_clear_o,
   output logic [11:0] memory_address_register_o,
   output logic [11:0] program_counter_o,
   output logic [11:0] memory_buffer_o,
   output logic [11:0] major_bus_o,
   output mfseq_pkg::mfseq_core_type core_o
);
   import mfseq_pkg::*;

   typedef struct packed {
      logic [4:0] key_prev;
      logic [4:0] filt;
      logic [4:0][31:0] fcnt;
      mfseq_phase_type phase;
      logic [31:0] tcnt;
      logic [31:0] pcnt;
      logic [1:0] pulse_sel;
      logic first_ff;
      logic second_ff;
      logic [4:0] held;
      logic setloc_l;
      logic store_l;
      logic insp_store_l;
      logic [11:0] mar;
      logic [11:0] pc;
      logic [11:0] mb;
   } mfseq_state_type;

   mfseq_state_type st_r;
   mfseq_state_type st_nxt;
   logic [4:0] key_vec;
   logic [4:0] rise;
   mfseq_keys_type rise_k;
   logic edge_second;
   logic edge_third;
   logic pulse_on;
   logic [11:0] bus_mux;
   logic [63:0] y_dec;

   assign key_vec = keys_i;

   // filter about to rise: worked from registered state so the chain logic has no loop
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_filt
         assign rise[g] = key_vec[g] & (key_vec[g] == st_r.key_prev[g]) & ~st_r.filt[g] &
            (st_r.fcnt[g] >= 32'(FILTER_CYC - 1));
      end
   endgenerate
   // name the rising keys by field so bit order of the struct cannot be mixed up
   assign rise_k = rise;

   // pulse window active flag
   assign pulse_on = (st_r.pcnt != 32'h0);

   // bus source selection during manual states
   always_comb begin
      bus_mux = bus_i;
      if (ctrl_o.switch_bus_gate) begin
         bus_mux = switch_register_i;
      end else if (ctrl_o.counter_bus_gate) begin
         bus_mux = st_r.pc;
      end else if (ctrl_o.address_reg_bus_gate) begin
         bus_mux = st_r.mar + {11'h000, ctrl_o.carry_insert};
      end
   end

   // y axis one-hot decode from high address bits
   always_comb begin
      y_dec = 64'h0;
      y_dec[st_r.mar[11:`MFSEQ_YSEL_LSB]] = 1'b1;
   end

   // next-state logic for filters, chain and registers
   always_comb begin
      st_nxt = st_r;
      st_nxt.key_prev = key_vec;
      for (int i = 0; i < 5; i++) begin
         if (key_vec[i] != st_r.key_prev[i]) begin
            st_nxt.fcnt[i] = 32'h0;
         end else if (key_vec[i] != st_r.filt[i]) begin
            if (st_r.fcnt[i] >= 32'(FILTER_CYC - 1)) begin
               st_nxt.filt[i] = key_vec[i];
               st_nxt.fcnt[i] = 32'h0;
            end else begin
               st_nxt.fcnt[i] = st_r.fcnt[i] + 32'h1;
            end
         end else begin
            st_nxt.fcnt[i] = 32'h0;
         end
      end
      if (pulse_on) begin
         st_nxt.pcnt = st_r.pcnt - 32'h1;
      end
      unique case (st_r.phase)
         MF_IDLE: begin
            // presses while running are dropped, no levels or pulses
            if ((|rise) && !run_i) begin
               st_nxt.phase = MF_S0;
               st_nxt.held = rise;
               st_nxt.setloc_l = rise_k.set_location;
               st_nxt.store_l = rise_k.store_word;
               st_nxt.insp_store_l = rise_k.inspect | rise_k.store_word;
            end
         end
         MF_S0: begin
            // initial state lasts one cycle: set first flop, fire initial pulse
            st_nxt.first_ff = 1'b1;
            st_nxt.pcnt = 32'(PULSE_CYC);
            st_nxt.pulse_sel = 2'd0;
            st_nxt.tcnt = 32'h0;
            st_nxt.phase = MF_S1;
         end
         MF_S1: begin
            st_nxt.tcnt = st_r.tcnt + 32'h1;
            if (st_r.tcnt == 32'(GAP_CYC - 1)) begin
               st_nxt.second_ff = 1'b1;
               st_nxt.first_ff = 1'b0;
               st_nxt.pcnt = 32'(PULSE_CYC);
               st_nxt.pulse_sel = 2'd1;
               st_nxt.tcnt = 32'h0;
               st_nxt.phase = MF_S2;
            end
         end
         MF_S2: begin
            st_nxt.tcnt = st_r.tcnt + 32'h1;
            if (st_r.tcnt == 32'(GAP_CYC - 1)) begin
               st_nxt.second_ff = 1'b0;
               st_nxt.pcnt = 32'(PULSE_CYC);
               st_nxt.pulse_sel = 2'd2;
               st_nxt.phase = MF_WAIT_REL;
            end
         end
         MF_WAIT_REL: begin
            // wait for the pulse to end and the key to be released
            if (!pulse_on && ((st_r.filt & st_r.held) == 5'h0)) begin
               st_nxt.phase = MF_IDLE;
               st_nxt.held = 5'h0;
            end
         end
         default: st_nxt.phase = MF_IDLE;
      endcase
      // address and counter loads happen on the first cycle of the second and third pulses
      if (ctrl_o.address_reg_strobe) begin
         st_nxt.mar = bus_mux;
      end
      if (ctrl_o.counter_strobe) begin
         st_nxt.pc = bus_mux;
      end
      if (time_pulse_two_i) begin
         st_nxt.mb = bus_mux;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // manual levels and pulses
   logic pulse_edge;
   assign pulse_edge = (st_r.pcnt == 32'(PULSE_CYC));
   assign manual_state_initial_o = (st_r.phase == MF_S0);
   assign manual_state_first_o = st_r.first_ff;
   assign manual_state_second_o = st_r.second_ff;
   // final level only meaningful once chain reached its end
   assign manual_state_final_o = ~st_r.second_ff & (st_r.phase == MF_WAIT_REL);
   assign manual_pulse_initial_o = pulse_on & (st_r.pulse_sel == 2'd0);
   assign manual_pulse_second_o = pulse_on & (st_r.pulse_sel == 2'd1);
   assign manual_pulse_third_o = pulse_on & (st_r.pulse_sel == 2'd2);

   // first cycle of a pulse still belongs to the state it ends, so gates hold over it
   assign edge_second = pulse_edge & (st_r.pulse_sel == 2'd1);
   assign edge_third = pulse_edge & (st_r.pulse_sel == 2'd2);

   // control gating; start and resume share the chain and memory start only
   always_comb begin
      ctrl_o = '0;
      ctrl_o.preset = manual_pulse_initial_o & (st_r.setloc_l | st_r.store_l);
      ctrl_o.run_clear_enable = manual_state_initial_o & st_r.insp_store_l;
      ctrl_o.switch_bus_gate = (st_r.setloc_l & (st_r.first_ff | st_r.second_ff | edge_third)) |
         (st_r.store_l & manual_state_final_o & ~edge_third);
      ctrl_o.counter_bus_gate = st_r.store_l & (st_r.first_ff | edge_second);
      ctrl_o.address_reg_bus_gate = st_r.store_l &
         ((st_r.second_ff & ~edge_second) | edge_third);
      ctrl_o.carry_insert = st_r.store_l &
         ((st_r.second_ff & ~edge_second) | edge_third);
      ctrl_o.address_reg_strobe = pulse_edge & (st_r.pulse_sel == 2'd1) &
         (st_r.setloc_l | st_r.store_l);
      ctrl_o.counter_strobe = pulse_edge & (st_r.pulse_sel == 2'd2) &
         (st_r.setloc_l | st_r.store_l);
      ctrl_o.mem_start = pulse_edge & (st_r.pulse_sel == 2'd2) &
         ~st_r.setloc_l;
   end

   // preset forces time state one and clears the others
   assign time_state_one_o = ctrl_o.preset;
   assign time_state_clear_o = {3{ctrl_o.preset}};

   assign memory_address_register_o = st_r.mar;
   assign program_counter_o = st_r.pc;
   assign memory_buffer_o = st_r.mb;
   assign major_bus_o = bus_mux;

   // same y line for read and write; only the current direction flips
   always_comb begin
      core_o.read_drive = mem_read_i & ~mem_write_i;
      core_o.write_drive = mem_write_i & ~mem_read_i;
      core_o.y_line = (mem_read_i | mem_write_i) ? y_dec : 64'h0;
      core_o.inhibit = mem_write_i ? ~st_r.mb : 12'h000;
   end
endmodule
`default_nettype wire

// ===== verif/mfseq_assertions.sv
// concurrent checks on the manual function sequencer ports
`timescale 1ns/1ns
`default_nettype none
module mfseq_assertions #(
   parameter int GAP_CYC = 100
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic manual_state_initial_o,
   input wire logic manual_state_first_o,
   input wire logic manual_state_second_o,
   input wire logic manual_state_final_o,
   input wire logic manual_pulse_initial_o,
   input wire logic manual_pulse_second_o,
   input wire logic manual_pulse_third_o,
   input wire logic [11:0] memory_address_register_o,
   input wire logic [11:0] memory_buffer_o,
   input wire mfseq_pkg::mfseq_core_type core_o
);
   import mfseq_pkg::*;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   // pulse length is fixed at eight clocks, inside the allowed window
   property p_pulse_width;
      $rose(manual_pulse_initial_o) |-> manual_pulse_initial_o[*8] ##1 !manual_pulse_initial_o;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("pulse width off");
   property p_gap_second;
      $rose(manual_pulse_initial_o) |-> ##GAP_CYC $rose(manual_pulse_second_o);
   endproperty
   a_gap_second: assert property (p_gap_second) else $error("second pulse late");
   property p_gap_third;
      $rose(manual_pulse_second_o) |-> ##GAP_CYC $rose(manual_pulse_third_o);
   endproperty
   a_gap_third: assert property (p_gap_third) else $error("third pulse late");
   property p_run_gate;
      $rose(manual_state_initial_o) |-> !$past(run_i);
   endproperty
   a_run_gate: assert property (p_run_gate) else $error("chain while running");
   property p_first_state;
      $rose(manual_state_initial_o) |=> manual_pulse_initial_o && manual_state_first_o;
   endproperty
   a_first_state: assert property (p_first_state) else $error("first state missing");
   // the flops may settle one clock after the pulse edge
   property p_second_state;
      $rose(manual_pulse_second_o) |-> ##[0:1] (manual_state_second_o && !manual_state_first_o);
   endproperty
   a_second_state: assert property (p_second_state) else $error("second state wrong");
   property p_final_state;
      $rose(manual_pulse_third_o) |-> ##[0:1] (!manual_state_second_o && manual_state_final_o);
   endproperty
   a_final_state: assert property (p_final_state) else $error("final state wrong");
   property p_inhibit;
      core_o.write_drive |-> core_o.inhibit == ~memory_buffer_o;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit pattern wrong");
   property p_ysel;
      (core_o.read_drive || core_o.write_drive) |->
         core_o.y_line == (64'h1 << memory_address_register_o[11:6]);
   endproperty
   a_ysel: assert property (p_ysel) else $error("y line decode wrong");
endmodule
`default_nettype wire

// ===== verif/mfseq_console.sv
// console model: bouncing key contacts and the switch register
`timescale 1ns/1ns
`default_nettype none
module mfseq_console (
   input wire logic core_clk_i,
   output mfseq_pkg::mfseq_keys_type keys_o,
   output logic [11:0] switch_register_o
);
   import mfseq_pkg::*;
   // keys up and switches down at power on
   initial begin
      keys_o = '0;
      switch_register_o = 12'h000;
   end
   // contacts chatter before settling, so the filter has real work
   task automatic set_key(input int k, input logic lvl, input logic [11:0] sw);
      logic [4:0] m;
      m = 5'h10 >> k;
      @(posedge core_clk_i);
      switch_register_o <= sw;
      repeat (5) begin
         @(posedge core_clk_i);
         keys_o <= keys_o ^ m;
      end
      @(posedge core_clk_i);
      keys_o <= lvl ? (keys_o | m) : (keys_o & ~m);
   endtask
endmodule
`default_nettype wire

// ===== verif/tb_mfseq_top.sv
// self-checking bench for the manual function sequencer
`timescale 1ns/1ns
`default_nettype none
`include "mfseq_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[FAIL] %0t value mismatch", $time); end end
module tb_mfseq_top;
   import mfseq_pkg::*;
   localparam int FILT = 20;
   typedef struct {int k; logic [11:0] sw; logic [3:0] f; logic [11:0] ma, pc;} mfseq_row_type;
   logic core_clk_i = 1'b0, rst_i = 1'b1, run_i = 1'b0, time_pulse_two_i = 1'b0;
   logic mem_read_i = 1'b0, mem_write_i = 1'b0, manual_state_initial_o, manual_state_final_o;
   logic [11:0] bus_i = 12'h5a5, switch_register_i, memory_address_register_o, program_counter_o;
   logic [11:0] memory_buffer_o, major_bus_o;
   logic [2:0] time_state_clear_o, seen;
   logic time_state_one_o;
   mfseq_keys_type keys_i;
   mfseq_ctrl_type ctrl_o;
   mfseq_core_type core_o;
   int tests_run = 0, n_mismatch = 0, n_init = 0, cyc = 0;
   // flags: preset, memory start, run clear, check registers
   mfseq_row_type rows [8] = '{
      '{`MFSEQ_KEY_SETLOC, 12'h0a5, 4'b1001, 12'h0a5, 12'h0a5},
      '{`MFSEQ_KEY_STORE, 12'h0c3, 4'b1111, 12'h0a5, 12'h0a6},
      '{`MFSEQ_KEY_STORE, 12'h0d4, 4'b1111, 12'h0a6, 12'h0a7},
      '{`MFSEQ_KEY_SETLOC, 12'hfff, 4'b1001, 12'hfff, 12'hfff},
      '{`MFSEQ_KEY_STORE, 12'h123, 4'b1111, 12'hfff, 12'h000},
      '{`MFSEQ_KEY_START, 12'h000, 4'b0100, 12'h000, 12'h000},
      '{`MFSEQ_KEY_INSPECT, 12'h000, 4'b0110, 12'h000, 12'h000},
      '{`MFSEQ_KEY_RESUME, 12'h000, 4'b0100, 12'h000, 12'h000}};
   mfseq_top #(.FILTER_CYC(FILT)) mfseq_top_i (.core_clk_i, .rst_i, .keys_i, .run_i,
      .switch_register_i, .bus_i, .time_pulse_two_i, .mem_read_i, .mem_write_i,
      .manual_state_initial_o, .manual_state_first_o(), .manual_state_second_o(),
      .manual_state_final_o, .manual_pulse_initial_o(), .manual_pulse_second_o(),
      .manual_pulse_third_o(), .ctrl_o, .time_state_one_o, .time_state_clear_o,
      .memory_address_register_o, .program_counter_o, .memory_buffer_o, .major_bus_o, .core_o);
   mfseq_console mfseq_console_i (.core_clk_i, .keys_o(keys_i), .switch_register_o(switch_register_i));
   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end
   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // gather what each chain emitted; sampled before the edge's own updates land
   always @(posedge core_clk_i) begin
      cyc++;
      if (manual_state_initial_o === 1'b1) n_init++;
      seen |= {ctrl_o.preset === 1'b1, ctrl_o.mem_start === 1'b1, ctrl_o.run_clear_enable === 1'b1};
      if (ctrl_o.preset === 1'b1) `CHK({time_state_one_o, time_state_clear_o}, 4'hf)
      if (cyc == 10000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // one press held past the chain, a memory cycle probed, then release
   task automatic run_row(input mfseq_row_type r);
      int n;
      n = 0;
      n_init = 0;
      seen = 3'b000;
      mfseq_console_i.set_key(r.k, 1'b1, r.sw);
      while (manual_state_final_o !== 1'b1 && n < 999) begin
         @(posedge core_clk_i);
         n++;
      end
      repeat (2 * FILT) @(posedge core_clk_i); // held key must not retrigger
      mem_read_i <= 1'b1;
      time_pulse_two_i <= 1'b1;
      @(posedge core_clk_i);
      time_pulse_two_i <= 1'b0;
      @(negedge core_clk_i);
      `CHK(n_init, 1)
      `CHK(seen[2], r.f[3])
      `CHK(seen[1], r.f[2])
      `CHK(seen[0], r.f[1])
      if (r.f[0]) begin
         `CHK({memory_address_register_o, program_counter_o}, {r.ma, r.pc})
         `CHK(core_o.y_line, 64'h1 << r.ma[11:6])
      end
      if (r.f[0] && r.f[2]) `CHK({major_bus_o, memory_buffer_o}, {r.sw, r.sw})
      @(posedge core_clk_i);
      mem_read_i <= 1'b0;
      mem_write_i <= 1'b1;
      repeat (2) @(negedge core_clk_i);
      `CHK({core_o.read_drive, core_o.write_drive, core_o.inhibit}, {2'b01, ~memory_buffer_o})
      @(posedge core_clk_i);
      mem_write_i <= 1'b0;
      mfseq_console_i.set_key(r.k, 1'b0, r.sw);
      repeat (3 * FILT) @(posedge core_clk_i);
   endtask
   // reset, table rows, a press while running, a reset mid-chain
   initial begin
      repeat (6) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(negedge core_clk_i);
      `CHK({major_bus_o, program_counter_o}, {bus_i, 12'h000})
      foreach (rows[i]) run_row(rows[i]);
      run_i <= 1'b1;
      n_init = 0;
      seen = 3'b000;
      mfseq_console_i.set_key(`MFSEQ_KEY_SETLOC, 1'b1, 12'h321);
      repeat (FILT + 300) @(posedge core_clk_i);
      `CHK({n_init[2:0], seen}, 6'h00)
      mfseq_console_i.set_key(`MFSEQ_KEY_SETLOC, 1'b0, 12'h321);
      repeat (3 * FILT) @(posedge core_clk_i);
      run_i <= 1'b0;
      mfseq_console_i.set_key(`MFSEQ_KEY_STORE, 1'b1, 12'h0f0);
      repeat (FILT + 20) @(posedge core_clk_i);
      rst_i <= 1'b1;
      @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(negedge core_clk_i);
      `CHK({manual_state_final_o, program_counter_o}, 13'h0000)
      mfseq_console_i.set_key(`MFSEQ_KEY_STORE, 1'b0, 12'h0f0);
      repeat (3 * FILT) @(posedge core_clk_i);
      run_row(rows[0]);
      wrap_up();
   end
endmodule
bind mfseq_top mfseq_assertions #(.GAP_CYC(GAP_CYC)) mfseq_assertions_i (.core_clk_i, .rst_i,
   .run_i, .manual_state_initial_o, .manual_state_first_o, .manual_state_second_o,
   .manual_state_final_o, .manual_pulse_initial_o, .manual_pulse_second_o,
   .manual_pulse_third_o, .memory_address_register_o, .memory_buffer_o, .core_o);
`default_nettype wire
